// ===== design/dsrerr_defines.vh
// Register map, field positions and reset values of the error and audio clock bank.
// Assumes byte-wide registers on a plain address/strobe port with 8-bit addresses.
`ifndef DSRERR_DEFINES_VH
`define DSRERR_DEFINES_VH

// ************************************************************
// Offsets
// ************************************************************
`define DSRERR_ADDR_W 8
`define DSRERR_DATA_W 8
`define DSRERR_OFS_RSVD_A 8'h07
`define DSRERR_OFS_RSVD_B 8'h08
`define DSRERR_OFS_RSVD_C 8'h09
`define DSRERR_OFS_RSVD_D 8'h0a
`define DSRERR_OFS_RSVD_E 8'h0b
`define DSRERR_OFS_LIMIT 8'h0c
`define DSRERR_OFS_DECCNT 8'h0d
`define DSRERR_OFS_PRBSCNT 8'h0e
`define DSRERR_OFS_MCLKCFG 8'h12
`define DSRERR_OFS_ID 8'h1e
`define DSRERR_OFS_REV 8'h1f

// ************************************************************
// Reset values and fields
// ************************************************************
`define DSRERR_RST_RSVD_A 8'h54
`define DSRERR_RST_RSVD_B 8'h30
`define DSRERR_RST_RSVD_C 8'hc8
`define DSRERR_RST_RSVD_D 8'h12
`define DSRERR_RST_RSVD_E 8'h20
`define DSRERR_RST_LIMIT 8'h00
`define DSRERR_RST_COUNT 8'h00
`define DSRERR_RST_MCLKCFG 8'h00
`define DSRERR_ZERO8 8'h00
`define DSRERR_CNT_MAX 8'hff
`define DSRERR_SRC_BIT 7
`define DSRERR_DIV_HI 6
`define DSRERR_DIV_LO 0
`define DSRERR_DIV_W 7
`define DSRERR_DIV_ZERO 7'h00
`define DSRERR_DIV_ONE 7'h01
`define DSRERR_REV_W 4

`endif

// ===== design/dsrerr_sat_counter.v
// Saturating 8-bit event counter with synchronous clear and hold-at-zero.
// Assumes the event input is already synchronous to core_clk.
`include "dsrerr_defines.vh"

module dsrerr_sat_counter (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Control
  input wire holdZero,
  input wire clear,
  input wire event_in,
  // Count
  output reg [`DSRERR_DATA_W-1:0] count
);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      count <= `DSRERR_RST_COUNT;
    end else if (holdZero || clear) begin
      count <= `DSRERR_ZERO8;
    end else if (event_in && count != `DSRERR_CNT_MAX) begin
      // Saturate rather than wrap so a burst never looks like a clean link
      count <= count + 8'h01;
    end
  end

endmodule // dsrerr_sat_counter

// ===== design/dsrerr_clk_div.v
// Divider producing the audio master clock from one of two source enables.
// Assumes both source ticks are one-cycle pulses synchronous to core_clk.
`include "dsrerr_defines.vh"

module dsrerr_clk_div (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Sources and setting
  input wire pixTick,
  input wire oscTick,
  input wire useOsc,
  input wire [`DSRERR_DIV_W-1:0] divide,
  // Divided output
  output reg mclkOut
);

  reg [`DSRERR_DIV_W-1:0] tickCnt;
  reg [`DSRERR_DIV_W-1:0] next_tickCnt;
  wire srcTick;

  assign srcTick = useOsc ? oscTick : pixTick;

  // Next position within the period, wrapped at the divider value
  always @* begin
    next_tickCnt = tickCnt + `DSRERR_DIV_ONE;
    if (next_tickCnt >= divide) begin
      next_tickCnt = `DSRERR_DIV_ZERO;
    end
  end

  // A divider of zero parks the output low; odd settings give an uneven duty
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tickCnt <= `DSRERR_DIV_ZERO;
      mclkOut <= 1'b0;
    end else if (divide == `DSRERR_DIV_ZERO) begin
      tickCnt <= `DSRERR_DIV_ZERO;
      mclkOut <= 1'b0;
    end else if (srcTick) begin
      tickCnt <= next_tickCnt;
      // High for the first half of the period, rounded up; a divider of one stays high
      mclkOut <= next_tickCnt < (divide - (divide >> 1));
    end
  end

endmodule // dsrerr_clk_div

// ===== design/dsrerr_regs.v
// Error threshold, error counters, audio clock setting and identity registers.
// Assumes software uses a one-cycle strobe port; link events are pins.
//
// The address-and-strobe port was decided locally.
`include "dsrerr_defines.vh"

// Contract
// - Writable 8-bit error limit, resets to zero
// - Error output low when count exceeds limit
// - Read-only 8-bit decode error counter, zero at reset
// - Counter held at zero during test pattern mode
// - Source bit picks pixel clock or oscillator
module dsrerr_regs #(
  parameter [7:0] DEVICE_ID = 8'h5a,      // Arbitrary value
  parameter [3:0] DEVICE_REV = 4'h1       // Arbitrary value
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register port
  input wire [`DSRERR_ADDR_W-1:0] regAddr,
  input wire [`DSRERR_DATA_W-1:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [`DSRERR_DATA_W-1:0] regRdData,
  // Link events (pins, asynchronous)
  input wire decodeFaultPin,
  input wire testPatternFaultPin,
  input wire testPatternModePin,
  input wire pixelClockTickPin,
  input wire oscTickPin,
  // Outputs
  output reg errorOut_n,
  output reg audioMasterClock
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg [4:0] syncA;
  reg [4:0] syncB;
  reg decPrev;
  reg prbsPrev;
  reg pixPrev;
  reg oscPrev;
  wire decEvent;
  wire prbsEvent;
  wire pixTick;
  wire oscTick;
  wire testMode;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
      decPrev <= 1'b0;
      prbsPrev <= 1'b0;
      pixPrev <= 1'b0;
      oscPrev <= 1'b0;
    end else begin
      syncA <= {oscTickPin, pixelClockTickPin, testPatternModePin,
                testPatternFaultPin, decodeFaultPin};
      syncB <= syncA;
      decPrev <= syncB[0];
      prbsPrev <= syncB[1];
      pixPrev <= syncB[3];
      oscPrev <= syncB[4];
    end
  end

  // Rising edges of the second stage for the four event pins, so each pin event counts once; test mode is taken as a level
  assign decEvent = syncB[0] & ~decPrev;
  assign prbsEvent = syncB[1] & ~prbsPrev;
  assign testMode = syncB[2];
  assign pixTick = syncB[3] & ~pixPrev;
  assign oscTick = syncB[4] & ~oscPrev;

  // ************************************************************
  // Registers
  // ************************************************************
  reg [`DSRERR_DATA_W-1:0] decodeFaultLimit;
  reg [`DSRERR_DATA_W-1:0] audioClockConfig;
  wire [`DSRERR_DATA_W-1:0] decodeFaultCount;
  wire [`DSRERR_DATA_W-1:0] testPatternFaultCount;
  wire audioMasterClockSource;
  wire [`DSRERR_DIV_W-1:0] audioMasterClockDivider;
  wire clkDivOut;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      decodeFaultLimit <= `DSRERR_RST_LIMIT;
      audioClockConfig <= `DSRERR_RST_MCLKCFG;
    end else if (regWrite) begin
      if (regAddr == `DSRERR_OFS_LIMIT) begin
        decodeFaultLimit <= regWrData;
      end
      if (regAddr == `DSRERR_OFS_MCLKCFG) begin
        audioClockConfig <= regWrData;
      end
    end
  end

  assign audioMasterClockSource = audioClockConfig[`DSRERR_SRC_BIT];
  assign audioMasterClockDivider = audioClockConfig[`DSRERR_DIV_HI:`DSRERR_DIV_LO];

  // ************************************************************
  // Counters
  // ************************************************************
  dsrerr_sat_counter uDecCount (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .holdZero(testMode),
    .clear(1'b0),
    .event_in(decEvent),
    .count(decodeFaultCount)
  );

  // Test pattern errors only mean something while the test runs
  dsrerr_sat_counter uPrbsCount (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .holdZero(1'b0),
    .clear(1'b0),
    .event_in(prbsEvent & testMode),
    .count(testPatternFaultCount)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      errorOut_n <= 1'b1;
    end else begin
      errorOut_n <= ~(decodeFaultCount > decodeFaultLimit);
    end
  end

  dsrerr_clk_div uClkDiv (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pixTick(pixTick),
    .oscTick(oscTick),
    .useOsc(audioMasterClockSource),
    .divide(audioMasterClockDivider),
    .mclkOut(clkDivOut)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      audioMasterClock <= 1'b0;
    end else begin
      audioMasterClock <= clkDivOut;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  // Unmapped addresses and writes to read-only places read back zero / are ignored
  always @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData <= `DSRERR_ZERO8;
    end else if (regRead) begin
      case (regAddr)
        `DSRERR_OFS_RSVD_A: regRdData <= `DSRERR_RST_RSVD_A;
        `DSRERR_OFS_RSVD_B: regRdData <= `DSRERR_RST_RSVD_B;
        `DSRERR_OFS_RSVD_C: regRdData <= `DSRERR_RST_RSVD_C;
        `DSRERR_OFS_RSVD_D: regRdData <= `DSRERR_RST_RSVD_D;
        `DSRERR_OFS_RSVD_E: regRdData <= `DSRERR_RST_RSVD_E;
        `DSRERR_OFS_LIMIT: regRdData <= decodeFaultLimit;
        `DSRERR_OFS_DECCNT: regRdData <= decodeFaultCount;
        `DSRERR_OFS_PRBSCNT: regRdData <= testPatternFaultCount;
        `DSRERR_OFS_MCLKCFG: regRdData <= audioClockConfig;
        `DSRERR_OFS_ID: regRdData <= DEVICE_ID;
        `DSRERR_OFS_REV: regRdData <= {{`DSRERR_REV_W{1'b0}}, DEVICE_REV};
        default: regRdData <= `DSRERR_ZERO8;
      endcase
    end else begin
      regRdData <= `DSRERR_ZERO8;
    end
  end

endmodule // dsrerr_regs

// ===== sim/dsrerr_regs_monitor.sv
// Port checker of the error and audio clock bank.
// Assumes one clock and a synchronous active-low reset; bound below.
module dsrerr_monitor (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  // Pins
  input wire testPatternModePin,
  input wire errorOut_n,
  input wire audioMasterClock
);
  reg [7:0] limit;
  reg [7:0] cfg;
  reg [3:0] modeCnt;
  // Shadows of the writable settings, and a count of cycles in test mode that stops at 8
  always @(posedge core_clk) begin
    if (!rst_n) begin
      limit <= 8'h00;
      cfg <= 8'h00;
      modeCnt <= 4'h0;
    end else begin
      if (regWrite && regAddr == 8'h0c) limit <= regWrData;
      if (regWrite && regAddr == 8'h12) cfg <= regWrData;
      if (!testPatternModePin) modeCnt <= 4'h0;
      else if (modeCnt != 4'h8) modeCnt <= modeCnt + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside its slot");
  limit_read_a: assert property (regRead && regAddr == 8'h0c |=> regRdData == limit)
    else $error("limit reads back wrong");
  cfg_read_a: assert property (regRead && regAddr == 8'h12 |=> regRdData == cfg)
    else $error("clock setting reads back wrong");
  mclk_stop_a: assert property ((cfg[6:0] == 7'h00) [*3] |-> !audioMasterClock)
    else $error("audio clock runs with divider zero");
  err_mode_a: assert property (modeCnt == 4'h8 |-> errorOut_n)
    else $error("error output low with zero count");
  cnt_mode_a: assert property (regRead && regAddr == 8'h0d && modeCnt == 4'h8 |=> regRdData == 8'h00)
    else $error("decode count not held in test mode");
endmodule // dsrerr_monitor

bind dsrerr_regs dsrerr_monitor mon (.core_clk, .rst_n, .regAddr, .regWrData, .regWrite,
  .regRead, .regRdData, .testPatternModePin, .errorOut_n, .audioMasterClock);

// ===== sim/deser_error_mclk_regs_bench.sv
// Self-checking bench of dsrerr_regs: map, error output, counters, audio clock.
// Assumes the design and its checker are compiled ahead of this file.
module deser_error_mclk_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'ha5; // Arbitrary value
  localparam logic [3:0] REV = 4'h3; // Arbitrary value
  logic core_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, pend = 0, lastM = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
  logic [4:0] pin = 5'h00;
  logic [31:0] rng = 32'h0000003a;
  wire [7:0] regRdData;
  wire errorOut_n, audioMasterClock;
  logic [7:0] expQ[$];
  int miscompares = 0, samples_checked = 0, seen = 0;
  logic [7:0] ra[12] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h12,
    8'h1e, 8'h1f, 8'h20};
  logic [7:0] rv[12] = '{8'h54, 8'h30, 8'hc8, 8'h12, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
    ID, {4'h0, REV}, 8'h00};
  dsrerr_regs #(.DEVICE_ID(ID), .DEVICE_REV(REV)) DUT (.core_clk, .rst_n, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .decodeFaultPin(pin[0]),
    .testPatternFaultPin(pin[1]), .testPatternModePin(pin[2]), .pixelClockTickPin(pin[3]),
    .oscTickPin(pin[4]), .errorOut_n, .audioMasterClock);
  initial forever #25 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Read data stand one cycle after the strobe: compare against the oldest note
  always @(posedge core_clk) begin
    if (pend) chk(regRdData, expQ.pop_front());
    pend = regRead;
    seen += (audioMasterClock !== lastM);
    lastM = audioMasterClock;
  end
  // Strobes stay up until the next call, so back-to-back cycles never reassign in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWrData <= d;
    if (!w) expQ.push_back(d);
    @(posedge core_clk);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    t = t ^ (t << 5);
    return t;
  endfunction
  task automatic idle(input int n);
    regWrite <= 0;
    regRead <= 0;
    repeat (n) @(posedge core_clk);
  endtask
  // Pins need one sampled cycle each way to pass the synchronisers; each level is held three
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      pin[i] <= 1;
      repeat (3) @(posedge core_clk);
      pin[i] <= 0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task automatic ticks(input int i, input logic run);
    seen = 0;
    pulse(i, 8);
    chk({7'h00, seen > 0}, {7'h00, run});
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    foreach (ra[k]) bus(0, ra[k], rv[k]);
    bus(1, 8'h07, 8'hff);
    bus(1, 8'h0d, 8'hff);
    bus(0, 8'h07, 8'h54);
    bus(0, 8'h0d, 8'h00);
    repeat (4) begin
      rng = xs(rng);
      bus(1, 8'h0c, rng[7:0]);
      bus(0, 8'h0c, rng[7:0]);
    end
    bus(1, 8'h0c, 8'h02);
    idle(2);
    pulse(0, 2);
    chk({7'h00, errorOut_n}, 8'h01);
    pulse(0, 1);
    chk({7'h00, errorOut_n}, 8'h00);
    bus(0, 8'h0d, 8'h03);
    idle(2);
    pin[2] <= 1;
    idle(8);
    pulse(0, 2);
    pulse(1, 2);
    chk({7'h00, errorOut_n}, 8'h01);
    bus(0, 8'h0d, 8'h00);
    bus(0, 8'h0e, 8'h02);
    bus(1, 8'h12, 8'h82);
    idle(3);
    pin[2] <= 0;
    ticks(4, 1);
    ticks(3, 0);
    bus(1, 8'h12, 8'h02);
    bus(0, 8'h12, 8'h02);
    idle(3);
    ticks(3, 1);
    ticks(4, 0);
    bus(1, 8'h12, 8'h00);
    idle(4);
    ticks(3, 0);
    chk({7'h00, audioMasterClock}, 8'h00);
    rst_n <= 0;
    idle(2);
    rst_n <= 1;
    @(posedge core_clk);
    bus(0, 8'h0c, 8'h00);
    bus(0, 8'h12, 8'h00);
    idle(3);
    test_done();
  end
endmodule // deser_error_mclk_regs_bench
